//--- verilog/gtc_consts.svh
// Constants for the general timer with capture: offsets, fields, resets, limits.
`ifndef GTC_CONSTS_SVH
`define GTC_CONSTS_SVH

// Register byte addresses on the register port.
`define GTC_ADDR_RELOAD 32'hffff0380
`define GTC_ADDR_COUNT 32'hffff0384
`define GTC_ADDR_CTRL 32'hffff0388
`define GTC_ADDR_ICLR 32'hffff038c
`define GTC_ADDR_CAPT 32'hffff0390
`define GTC_ADDR_STAT 32'hffff0394
`define GTC_ADDR_MASK 32'hffff0398

// Reset values.
`define GTC_RST_WORD 32'h00000000
`define GTC_RST_IRQ 2'h0

// Control and status field positions.
`define GTC_CTRL_LIVE_MSB 17
`define GTC_STS_TIMEOUT 0
`define GTC_STS_CAPTURE 1

// Prescaler terminal counts (division minus one).
`define GTC_PRE_MAX_16 15'h000f
`define GTC_PRE_MAX_256 15'h00ff
`define GTC_PRE_MAX_32K 15'h7fff

// Time-of-day field limits.
`define GTC_HUND_MAX 8'h63
`define GTC_MINSEC_MAX 8'h3b
`define GTC_HOUR_MAX_23 8'h17
`define GTC_HOUR_MAX_255 8'hff

`endif

//--- verilog/gtc_pkg.sv
// Types shared by the general timer with capture.
`default_nettype none
package gtc_pkg;

  // Count format selection.
  typedef enum logic [1:0] {
    GTC_FMT_BIN = 2'b00,
    GTC_FMT_RSVD = 2'b01,
    GTC_FMT_TOD23 = 2'b10,
    GTC_FMT_TOD255 = 2'b11
  } gtc_fmt_t;

  // Prescaler source selection.
  typedef enum logic [2:0] {
    GTC_SRC_SLOW = 3'b000,
    GTC_SRC_CORE = 3'b001,
    GTC_SRC_PLL_A = 3'b010,
    GTC_SRC_PLL_B = 3'b011
  } gtc_src_t;

  // Layout of the control register, most significant field first.
  typedef struct packed {
    logic [13:0] reserved;
    logic capture_en;
    logic [4:0] event_sel;
    logic [2:0] clk_sel;
    logic count_up;
    logic enable;
    logic periodic;
    logic [1:0] format;
    logic [3:0] prescale;
  } gtc_ctrl_t;

  // One register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gtc_req_t;

endpackage : gtc_pkg
`default_nettype wire

//--- verilog/gtc_timer.sv
// General-purpose 32-bit timer with prescaler, time-of-day format and event capture.
//
// Contract
// - Thirty-two bit unsigned counter, up or down.
// - Control bit 8 chooses up; reset down.
// - Bits 11:9 choose slow, core or PLL.
// - Bits 3:0 divide by 1, 16, 256, 32768.
// - Format: binary, 23-hour or 255-hour time.
// - Each rising edge of selected event copies count, counting continues.
// - Bit 17 enables capture; bits 16:12 pick event.
// - Bit 7 enables counting; disabled after reset.
// - Bit 6 periodic, else free-running; reset free.
// - Reload on clear write, and on overflow in periodic mode.
// - Any clear write clears the timer interrupt; an overflow in the same cycle keeps it set.
// - Low power: only slow oscillator keeps counting.
// - Count and capture registers ignore writes.
//
// Decided for this implementation: the strobed register port.
`include "gtc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module gtc_timer #(
  parameter int EVT_NUM = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic slow_osc_in,
  input wire logic undivided_pll_clock_in,
  input wire logic low_power_in,
  input wire logic [EVT_NUM-1:0] event_in,
  output logic irq_out
);

  // The event select field is five bits wide, so exactly 32 sources are served.
  if (EVT_NUM != 32) begin : g_bad_evt
    $error("EVT_NUM must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers.

  logic rst_s1_r; // First reset stage, read only by the second.
  logic rst_sync_n; // Reset used by the rest of the block.
  logic [2:0] slow_sync_r; // Slow oscillator: two sync stages plus edge history.
  logic [2:0] pll_sync_r; // PLL clock pin: two sync stages plus edge history.
  logic [1:0] lp_sync_r; // Low-power request, synchronised.
  logic [EVT_NUM-1:0] evt_s1_r; // Event first stage.
  logic [EVT_NUM-1:0] evt_s2_r; // Event second stage.
  logic [EVT_NUM-1:0] evt_s3_r; // Event history for edge detection.

  // The reset is asserted at once and released cleanly through two flops.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // Pins arrive from other domains; nothing but the second stage reads stage one.
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slow_sync_r <= 3'h0;
      pll_sync_r <= 3'h0;
      lp_sync_r <= 2'h0;
      evt_s1_r <= '0;
      evt_s2_r <= '0;
      evt_s3_r <= '0;
    end else if (clk_en_in) begin
      slow_sync_r <= {slow_sync_r[1:0], slow_osc_in};
      pll_sync_r <= {pll_sync_r[1:0], undivided_pll_clock_in};
      lp_sync_r <= {lp_sync_r[0], low_power_in};
      evt_s1_r <= event_in;
      evt_s2_r <= evt_s1_r;
      evt_s3_r <= evt_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and register port decode.

  gtc_pkg::gtc_req_t req; // Bundled request of this cycle.
  gtc_pkg::gtc_ctrl_t ctrl_r; // Control register.
  logic [31:0] reload_r; // Reload value register.
  logic [31:0] count_r; // Current count.
  logic [31:0] count_nxt; // Next count.
  logic [31:0] cap_r; // Captured count.
  logic [1:0] sts_r; // Sticky interrupt status.
  logic [1:0] sts_nxt; // Next status.
  logic [1:0] mask_r; // Interrupt mask, one enables.
  logic [14:0] pre_r; // Prescaler count.
  logic [31:0] rd_data_r; // Registered read data.

  assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // Write decode; writes to the count and capture addresses select nothing.
  wire wr_reload = req.wr && (req.addr == `GTC_ADDR_RELOAD);
  wire wr_ctrl = req.wr && (req.addr == `GTC_ADDR_CTRL);
  wire wr_clr = req.wr && (req.addr == `GTC_ADDR_ICLR);
  wire wr_stat = req.wr && (req.addr == `GTC_ADDR_STAT);
  wire wr_mask = req.wr && (req.addr == `GTC_ADDR_MASK);

  // Read selection; the clear register and unmapped addresses read zero.
  wire [31:0] rd_mux =
    (req.addr == `GTC_ADDR_RELOAD) ? reload_r :
    (req.addr == `GTC_ADDR_COUNT) ? count_r :
    (req.addr == `GTC_ADDR_CTRL) ? 32'(ctrl_r) :
    (req.addr == `GTC_ADDR_CAPT) ? cap_r :
    (req.addr == `GTC_ADDR_STAT) ? {30'h0, sts_r} :
    (req.addr == `GTC_ADDR_MASK) ? {30'h0, mask_r} : `GTC_RST_WORD;

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection and prescaler.

  // Terminal prescaler count for a division code; undefined codes divide by one.
  function automatic logic [14:0] pre_max(input logic [3:0] code);
    case (code)
      4'b0100: pre_max = `GTC_PRE_MAX_16;
      4'b1000: pre_max = `GTC_PRE_MAX_256;
      4'b1111: pre_max = `GTC_PRE_MAX_32K;
      default: pre_max = 15'h0000;
    endcase
  endfunction : pre_max

  // Rising edges of the synchronised pins; the history stage is the only other reader.
  wire slow_edge = slow_sync_r[1] && !slow_sync_r[2];
  wire pll_edge = pll_sync_r[1] && !pll_sync_r[2];
  wire low_power = lp_sync_r[1];
  wire src_is_slow = (ctrl_r.clk_sel == gtc_pkg::GTC_SRC_SLOW);

  // Source tick; in low power only the slow oscillator keeps running.
  wire src_raw =
    (ctrl_r.clk_sel == gtc_pkg::GTC_SRC_SLOW) ? slow_edge :
    (ctrl_r.clk_sel == gtc_pkg::GTC_SRC_CORE) ? 1'b1 :
    (ctrl_r.clk_sel == gtc_pkg::GTC_SRC_PLL_A) ? pll_edge :
    (ctrl_r.clk_sel == gtc_pkg::GTC_SRC_PLL_B) ? pll_edge : 1'b0;
  wire src_tick = src_raw && (!low_power || src_is_slow);

  wire [14:0] pre_lim = pre_max(ctrl_r.prescale);
  // Greater-or-equal, not equal: a smaller division written while the count is high
  // takes effect at the next source tick instead of running the whole range again.
  wire pre_done = (pre_r >= pre_lim);
  wire cnt_tick = ctrl_r.enable && src_tick && pre_done;

  // The prescaler restarts while the timer is stopped so a restart is clean.
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_r <= 15'h0000;
    end else if (clk_en_in) begin
      if (!ctrl_r.enable || (src_tick && pre_done)) begin
        pre_r <= 15'h0000;
      end else if (src_tick) begin
        pre_r <= pre_r + 15'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counting in binary and time-of-day formats.

  // One step of the counter; bit 32 flags an overflow or underflow.
  function automatic logic [32:0] step(input logic [31:0] v, input logic up,
                                       input logic [1:0] fmt);
    logic [7:0] hr;
    logic [7:0] mn;
    logic [7:0] sc;
    logic [7:0] hu;
    logic [7:0] hmax;
    hr = v[31:24];
    mn = v[23:16];
    sc = v[15:8];
    hu = v[7:0];
    hmax = (fmt == gtc_pkg::GTC_FMT_TOD23) ? `GTC_HOUR_MAX_23 : `GTC_HOUR_MAX_255;
    if (!fmt[1]) begin
      // Binary, including the reserved code.
      if (up) begin
        step = {(v == 32'hffffffff), v + 32'h00000001};
      end else begin
        step = {(v == 32'h00000000), v - 32'h00000001};
      end
    end else if (up) begin
      // Each field carries into the next when it passes its top value.
      if (hu < `GTC_HUND_MAX) begin
        step = {1'b0, hr, mn, sc, hu + 8'h01};
      end else if (sc < `GTC_MINSEC_MAX) begin
        step = {1'b0, hr, mn, sc + 8'h01, 8'h00};
      end else if (mn < `GTC_MINSEC_MAX) begin
        step = {1'b0, hr, mn + 8'h01, 8'h00, 8'h00};
      end else if (hr < hmax) begin
        step = {1'b0, hr + 8'h01, 8'h00, 8'h00, 8'h00};
      end else begin
        step = {1'b1, 32'h00000000};
      end
    end else begin
      // Borrows refill a field at its top value.
      if (hu != 8'h00) begin
        step = {1'b0, hr, mn, sc, hu - 8'h01};
      end else if (sc != 8'h00) begin
        step = {1'b0, hr, mn, sc - 8'h01, `GTC_HUND_MAX};
      end else if (mn != 8'h00) begin
        step = {1'b0, hr, mn - 8'h01, `GTC_MINSEC_MAX, `GTC_HUND_MAX};
      end else if (hr != 8'h00) begin
        step = {1'b0, hr - 8'h01, `GTC_MINSEC_MAX, `GTC_MINSEC_MAX, `GTC_HUND_MAX};
      end else begin
        step = {1'b1, hmax, `GTC_MINSEC_MAX, `GTC_MINSEC_MAX, `GTC_HUND_MAX};
      end
    end
  endfunction : step

  // The step is worked out every cycle and used only on a counting tick.
  wire [32:0] step_res = step(count_r, ctrl_r.count_up, ctrl_r.format);
  wire ovf_evt = cnt_tick && step_res[32];

  // A clear write reloads at once; an overflow reloads only in periodic mode.
  assign count_nxt =
    wr_clr ? reload_r :
    !cnt_tick ? count_r :
    (step_res[32] && ctrl_r.periodic) ? reload_r :
    step_res[31:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Capture and interrupt status.

  // Each rising edge of the selected event counts; a held level does not.
  wire evt_edge = evt_s2_r[ctrl_r.event_sel] && !evt_s3_r[ctrl_r.event_sel];
  wire cap_fire = ctrl_r.capture_en && evt_edge;

  // New events win over a clear in the same cycle, so none is lost.
  wire [1:0] sts_set = {cap_fire, ovf_evt};
  wire [1:0] sts_clr = (wr_stat ? req.wdata[1:0] : 2'h0) | {1'b0, wr_clr};
  assign sts_nxt = (sts_r & ~sts_clr) | sts_set;

  // Any request of this cycle that clears the timeout flag; the overflow check reads it.
  wire clr_timeout = sts_clr[`GTC_STS_TIMEOUT];

  // Configuration registers; reserved control bits are not stored.
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_r <= gtc_pkg::gtc_ctrl_t'(`GTC_RST_WORD);
      reload_r <= `GTC_RST_WORD;
      mask_r <= `GTC_RST_IRQ;
    end else if (clk_en_in) begin
      if (wr_ctrl) begin
        ctrl_r <= gtc_pkg::gtc_ctrl_t'({14'h0, req.wdata[`GTC_CTRL_LIVE_MSB:0]});
      end
      if (wr_reload) begin
        reload_r <= req.wdata;
      end
      if (wr_mask) begin
        mask_r <= req.wdata[1:0];
      end
    end
  end

  // Counter, capture and status; writes to the count and capture addresses reach neither.
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_r <= `GTC_RST_WORD;
      cap_r <= `GTC_RST_WORD;
      sts_r <= `GTC_RST_IRQ;
    end else if (clk_en_in) begin
      count_r <= count_nxt;
      sts_r <= sts_nxt;
      if (cap_fire) begin
        cap_r <= count_r;
      end
    end
  end

  // Read data appears in the cycle after the read strobe, and only there.
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data_r <= `GTC_RST_WORD;
    end else if (clk_en_in) begin
      rd_data_r <= req.rd ? rd_mux : `GTC_RST_WORD;
    end
  end

  assign reg_rdata_out = rd_data_r;
  // The interrupt is an AND-OR of flops only, so no decode glitch reaches the pin.
  assign irq_out = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_sync_n);
  // Checks sleep while the block is in reset, so stale values across a reset never fire them.

  a_clear_reload: assert property (
    clk_en_in && wr_clr |=> count_r == $past(reload_r))
    else $error("clear write did not reload the counter");

  a_stop_holds: assert property (
    clk_en_in && !ctrl_r.enable && !wr_clr |=> $stable(count_r))
    else $error("disabled counter changed");

  a_capture_copy: assert property (
    clk_en_in && cap_fire |=> cap_r == $past(count_r))
    else $error("capture did not copy the count");

  a_capture_ro: assert property (
    clk_en_in && req.wr && !cap_fire |=> $stable(cap_r))
    else $error("capture register changed without an event");

  a_clear_flag: assert property (
    clk_en_in && wr_clr && !ovf_evt |=> !sts_r[`GTC_STS_TIMEOUT])
    else $error("clear write left the timer flag set");

  a_ovf_flag: assert property (
    clk_en_in && ovf_evt |=> sts_r[`GTC_STS_TIMEOUT] ##1
      (sts_r[`GTC_STS_TIMEOUT] || $past(clr_timeout)))
    else $error("overflow did not set the sticky flag");

  a_up_step: assert property (
    clk_en_in && cnt_tick && ctrl_r.count_up && ctrl_r.format == 2'b00 && !wr_clr
      && count_r != 32'hffffffff |=> count_r == $past(count_r) + 32'h00000001)
    else $error("up count did not add one");

  a_hund_wrap: assert property (
    clk_en_in && cnt_tick && ctrl_r.count_up && ctrl_r.format[1] && !wr_clr
      && count_r[7:0] == 8'h63 && !step_res[32] |=> count_r[7:0] == 8'h00)
    else $error("hundredths did not wrap at 100");

  a_low_power: assert property (
    low_power && !src_is_slow |-> !src_tick)
    else $error("non-slow source ticked in low power");

  a_div16: assert property (
    clk_en_in && ctrl_r.prescale == 4'b0100 && ctrl_r.enable && cnt_tick |-> pre_r == 15'h000f)
    else $error("divide-by-16 ticked at the wrong count");

  // Wraps and steps; a clear write in the same cycle wins, so antecedents leave it out.
  a_periodic_reload: assert property (
    clk_en_in && ovf_evt && ctrl_r.periodic && !wr_clr |=> count_r == $past(reload_r))
    else $error("periodic wrap did not reload the counter");

  // A free-running binary count runs straight through the end of its range.
  a_free_wrap: assert property (
    clk_en_in && ovf_evt && !ctrl_r.periodic && !ctrl_r.format[1] && ctrl_r.count_up
      && !wr_clr |=> count_r == 32'h00000000)
    else $error("free-running up count did not wrap to zero");

  a_down_step: assert property (
    clk_en_in && cnt_tick && !ctrl_r.count_up && !ctrl_r.format[1] && !wr_clr
      && count_r != 32'h00000000 |=> count_r == $past(count_r) - 32'h00000001)
    else $error("down count did not subtract one");

  // The capture flag is set even when software clears it in the same cycle.
  a_capture_flag: assert property (
    clk_en_in && cap_fire |=> sts_r[`GTC_STS_CAPTURE])
    else $error("capture did not set its status flag");

  // The core clock ticks every cycle unless low power holds it back.
  a_core_tick: assert property (
    ctrl_r.clk_sel == gtc_pkg::GTC_SRC_CORE && !low_power |-> src_tick)
    else $error("core source did not tick");

  // Covers for the main scenarios.

  c_capture: cover property (cap_fire && ctrl_r.enable);
  c_periodic: cover property (ovf_evt && ctrl_r.periodic);
  c_tod_carry: cover property (cnt_tick && ctrl_r.format[1] && count_r[7:0] == 8'h63);
  c_irq: cover property (irq_out && wr_clr);
  c_low_power: cover property (low_power && src_is_slow && cnt_tick);

endmodule : gtc_timer
`default_nettype wire

//--- test/test_general_timer_with_capture.sv
// Self-checking bench for the general timer with capture.
`timescale 1ns/100ps
`default_nettype none
`include "gtc_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
`define RD(a, e) begin br(a, v); `CHK(v, e) end

module test_general_timer_with_capture;
  ////////////////////////////////////////////////////////////
  // Bench copies of every design input, all defined at time zero.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cke = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic pll = 1'b0;
  logic lp = 1'b0;
  logic [31:0] addr = '0;
  logic [31:0] wd = '0;
  logic [31:0] evt = '0;
  logic [31:0] rdata;
  logic irq;
  // Model state; the model ticks once per slow source pulse.
  logic [31:0] m_rel;
  logic [31:0] m_cnt;
  logic [31:0] m_ctl;
  bit m_ov;
  logic [31:0] v;
  logic [31:0] r;
  int bad_count = 0;
  int compares = 0;
  int k;
  int sel;
  // Counting cases: control word, reload value, number of ticks.
  logic [31:0] t_ctl[$] = '{32'h080, 32'h180, 32'h0c0, 32'h1c0, 32'h1a0,
    32'h1a0, 32'h1b0, 32'h0b0, 32'h0a0, 32'h0e0, 32'h190};
  logic [31:0] t_rel[$] = '{32'h0, 32'hfffffffe, 32'h2, 32'hfffffffd,
    32'h173b3b62, 32'h00003b63, 32'hfe3b3b63, 32'h0, 32'h01000000, 32'h1, 32'hffffffff};
  int t_n[$] = '{1, 3, 3, 4, 2, 1, 1, 1, 1, 2, 2};

  // Free-running clock, 10 ns period.
  always #5 clk = ~clk;

  gtc_timer #(.EVT_NUM(32)) uut (
    .ref_clk_in(clk),
    .rst_n_in(rst_n),
    .clk_en_in(cke),
    .reg_addr_in(addr),
    .reg_wdata_in(wd),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .slow_osc_in(slow),
    .undivided_pll_clock_in(pll),
    .low_power_in(lp),
    .event_in(evt),
    .irq_out(irq)
  );

  ////////////////////////////////////////////////////////////
  // One model tick; time formats carry field by field, binary is one field.
  function automatic void m_tick();
    longint f[4];
    longint lim[4];
    int n;
    int i;
    n = m_ctl[5] ? 4 : 1;
    f[0] = m_cnt;
    lim[0] = 64'hffffffff;
    if (n == 4) begin
      for (i = 0; i < 4; i++) f[i] = m_cnt[8*i +: 8];
      lim = '{99, 59, 59, m_ctl[4] ? 255 : 23};
    end
    i = 0;
    while (i < n) begin
      if (f[i] == (m_ctl[8] ? lim[i] : 0)) begin
        f[i] = m_ctl[8] ? 0 : lim[i];
        i++;
      end else begin
        f[i] += m_ctl[8] ? 1 : -1;
        break;
      end
    end
    m_cnt = (n == 1) ? 32'(f[0]) : {8'(f[3]), 8'(f[2]), 8'(f[1]), 8'(f[0])};
    // A wrap flags the event; periodic mode then takes the reload value.
    if (i == n) begin
      m_ov = 1'b1;
      if (m_ctl[6]) m_cnt = m_rel;
    end
  endfunction : m_tick

  // Register write: one strobe cycle.
  task automatic bw(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bw

  // Register read: data is taken in the single cycle after the strobe.
  task automatic br(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : br

  // Source pulses, long enough to pass the two-flop synchronisers.
  task automatic pulses(input int n, input bit on_pll);
    repeat (n) begin
      @(posedge clk);
      if (on_pll) pll <= 1'b1;
      else slow <= 1'b1;
      repeat (3) @(posedge clk);
      pll <= 1'b0;
      slow <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pulses

  // Load, reload through the clear register, then configure.
  task automatic start(input logic [31:0] rl, input logic [31:0] c);
    m_rel = rl;
    m_cnt = rl;
    m_ctl = c;
    m_ov = 1'b0;
    bw(`GTC_ADDR_RELOAD, rl);
    bw(`GTC_ADDR_ICLR, $urandom);
    bw(`GTC_ADDR_CTRL, c & 32'h0003ffff);
    `RD(`GTC_ADDR_CTRL, c)
    `RD(`GTC_ADDR_COUNT, rl)
  endtask : start

  // The output may come from a flop after the status, so allow a cycle.
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, e)
  endtask : irq_is

  task automatic finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected few thousand cycles.
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h999993d6));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Every register and one unmapped word read zero out of reset.
    for (k = 0; k < 8; k++) `RD(32'hffff0380 + 4 * k, 32'h0)
    r = $urandom;
    start(r, 32'h0);
    bw(`GTC_ADDR_COUNT, ~r);
    bw(`GTC_ADDR_CAPT, ~r);
    `RD(`GTC_ADDR_COUNT, r)
    `RD(`GTC_ADDR_CAPT, 32'h0)
    bw(`GTC_ADDR_CTRL, 32'hfffc0000);
    `RD(`GTC_ADDR_CTRL, 32'h0)
    @(posedge clk) cke <= 1'b0;
    bw(`GTC_ADDR_RELOAD, ~r);
    @(posedge clk) cke <= 1'b1;
    `RD(`GTC_ADDR_RELOAD, r)
    // Direction, mode and format cases, one random binary case last.
    t_ctl.push_back(32'h180);
    t_rel.push_back($urandom);
    t_n.push_back(1 + $urandom % 4);
    for (k = 0; k < t_n.size(); k++) begin
      start(t_rel[k], t_ctl[k]);
      pulses(t_n[k], 1'b0);
      repeat (t_n[k]) m_tick();
      `RD(`GTC_ADDR_COUNT, m_cnt)
      `RD(`GTC_ADDR_STAT, {31'h0, m_ov})
    end
    // Prescaler: one pulse short of the division leaves the count alone.
    for (k = 0; k < 3; k++) begin
      start(32'h0, 32'h180 | (k << 2));
      pulses((1 << (4 * k)) - 1, 1'b0);
      `RD(`GTC_ADDR_COUNT, 32'h0)
      pulses(1, 1'b0);
      `RD(`GTC_ADDR_COUNT, 32'h1)
    end
    start(32'h0, 32'h18f);
    pulses(5, 1'b0);
    `RD(`GTC_ADDR_COUNT, 32'h0)
    // Both PLL codes; in low power only the slow source may count.
    for (k = 2; k < 4; k++) begin
      start(32'h0, 32'h180 | (k << 9));
      @(posedge clk) lp <= 1'b1;
      pulses(3, 1'b1);
      pulses(2, 1'b0);
      `RD(`GTC_ADDR_COUNT, 32'h0)
      @(posedge clk) lp <= 1'b0;
      pulses(3, 1'b1);
      `RD(`GTC_ADDR_COUNT, 32'h3)
    end
    start(32'h0, 32'h180);
    @(posedge clk) lp <= 1'b1;
    pulses(2, 1'b0);
    `RD(`GTC_ADDR_COUNT, 32'h2)
    bw(`GTC_ADDR_CTRL, 32'h380);
    repeat (10) @(posedge clk);
    `RD(`GTC_ADDR_COUNT, 32'h2)
    @(posedge clk) lp <= 1'b0;
    repeat (20) @(posedge clk);
    bw(`GTC_ADDR_CTRL, 32'h300);
    br(`GTC_ADDR_COUNT, v);
    `CHK(v inside {[32'd20:32'd28]}, 1'b1)
    // Capture: other sources ignored, edge not level, none when disabled, counter keeps going.
    sel = $urandom % 32;
    r = $urandom & 32'h7fffffff;
    start(r, 32'h20180 | (sel << 12));
    @(posedge clk) evt <= ~(32'h1 << sel);
    pulses(2, 1'b0);
    `RD(`GTC_ADDR_CAPT, 32'h0)
    @(posedge clk) evt <= '1;
    repeat (4) @(posedge clk);
    pulses(1, 1'b0);
    `RD(`GTC_ADDR_CAPT, r + 32'h2)
    `RD(`GTC_ADDR_COUNT, r + 32'h3)
    `RD(`GTC_ADDR_STAT, 32'h2)
    bw(`GTC_ADDR_ICLR, 32'h0);
    `RD(`GTC_ADDR_CAPT, r + 32'h2)
    @(posedge clk) evt <= '0;
    bw(`GTC_ADDR_CTRL, 32'h180 | (sel << 12));
    @(posedge clk) evt <= '1;
    repeat (4) @(posedge clk);
    `RD(`GTC_ADDR_CAPT, r + 32'h2)
    // Interrupt: masking, write-one-to-clear, and the clear register.
    bw(`GTC_ADDR_MASK, 32'h2);
    irq_is(1'b1);
    bw(`GTC_ADDR_STAT, 32'h1);
    irq_is(1'b1);
    bw(`GTC_ADDR_STAT, 32'h2);
    irq_is(1'b0);
    `RD(`GTC_ADDR_MASK, 32'h2)
    start(32'h0, 32'h080);
    pulses(1, 1'b0);
    `RD(`GTC_ADDR_STAT, 32'h1)
    bw(`GTC_ADDR_MASK, 32'h1);
    irq_is(1'b1);
    bw(`GTC_ADDR_MASK, 32'h0);
    irq_is(1'b0);
    bw(`GTC_ADDR_MASK, 32'h1);
    irq_is(1'b1);
    bw(`GTC_ADDR_ICLR, $urandom);
    irq_is(1'b0);
    `RD(`GTC_ADDR_STAT, 32'h0)
    `RD(`GTC_ADDR_COUNT, 32'h0)
    // A second reset in mid-run returns the written registers to zero.
    bw(`GTC_ADDR_RELOAD, r | 32'h1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `RD(`GTC_ADDR_RELOAD, 32'h0)
    `RD(`GTC_ADDR_CTRL, 32'h0)
    finish_test();
  end
endmodule : test_general_timer_with_capture
`default_nettype wire
